/* File: core/ext_bus_port.sv */
`timescale 1ns/1ns
// How it works
// - The address latch strobe pulses at the start of each external cycle while both address bytes are driven.
// - One eight-bit three-state port carries the low address byte first and then the data byte.
// - With the code source select low, every program fetch goes over the external bus.
// - With the code source select high, program addresses below the on-chip ROM limit are fetched inside.
// - The code source select is sampled during reset and held until the next reset.
// - The upper address byte of every external access is driven on a dedicated eight-bit port.
// - The active-low program read strobe asserts for external program reads.
// - The active-low data read strobe asserts for external data reads, apart from the program strobe.
module ext_bus_port
  import ext_bus_pkg::*;
#(
  parameter logic [15:0] ROM_LIMIT = ROM_LIMIT_DEFAULT
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic req_valid,
  output logic req_ready,
  input wire logic [15:0] req_addr,
  input wire logic req_is_code,
  output logic resp_valid,
  output logic [7:0] resp_data,
  output logic resp_internal,
  output logic [15:0] rom_addr,
  input wire logic [7:0] rom_data,
  output logic address_latch_strobe,
  output logic [7:0] upper_address_lines,
  input wire logic [7:0] muxed_addr_data_lines_in,
  output logic [7:0] muxed_addr_data_lines_out,
  output logic [7:0] muxed_addr_data_lines_oe,
  output logic program_read_strobe_n,
  output logic data_read_strobe_n,
  input wire logic code_source_select,
  input wire logic host_interrupt_input,
  output logic modem_host_interrupt,
  output logic code_source_latched
);
  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  pin_sync_if pins ();
  assign pins.raw = {host_interrupt_input, code_source_select, muxed_addr_data_lines_in};

  pin_sync u_sync
  (
    .clk(clk),
    .rst_n(rst_n),
    .sig(pins)
  );

  logic [7:0] bus_in_sync;
  logic strap_sync;
  assign bus_in_sync = pins.synced[7:0];
  assign strap_sync = pins.synced[8];
  assign modem_host_interrupt = pins.synced[9];

  // ----------------------------------------
  // Strap capture
  // ----------------------------------------
  logic strap_reg;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      strap_reg <= strap_sync;
  end
  assign code_source_latched = strap_reg;

  // ----------------------------------------
  // Bus sequencer
  // ----------------------------------------
  bus_state_type state_reg;
  logic [CNT_W-1:0] cnt_reg;
  logic is_code_reg;
  logic [15:0] addr_reg;
  logic internal_hit;
  logic take;

  // Internal only when strap is high and the address is in ROM range.
  assign internal_hit = req_is_code && strap_reg && (req_addr < ROM_LIMIT);
  assign req_ready = (state_reg == ST_IDLE);
  assign take = req_valid && req_ready;
  assign rom_addr = req_addr;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      state_reg <= ST_IDLE;
      cnt_reg <= CNT_ZERO;
      is_code_reg <= 1'b0;
      addr_reg <= 16'h0000;
    end
    else
    begin
      unique case (state_reg)
        ST_IDLE:
        begin
          if (take && !internal_hit)
          begin
            state_reg <= ST_ADDR;
            addr_reg <= req_addr;
            is_code_reg <= req_is_code;
          end
        end
        ST_ADDR:
          state_reg <= ST_FLOAT;
        ST_FLOAT:
        begin
          state_reg <= ST_STROBE;
          cnt_reg <= CNT_W'(STROBE_CYCLES);
        end
        ST_STROBE:
        begin
          cnt_reg <= cnt_reg - CNT_ONE;
          if (cnt_reg == CNT_ONE)
            state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Pin drive
  // ----------------------------------------
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      address_latch_strobe <= 1'b0;
      upper_address_lines <= UPPER_RESET;
      muxed_addr_data_lines_out <= BYTE_ONES;
      muxed_addr_data_lines_oe <= BYTE_ZERO;
      program_read_strobe_n <= 1'b1;
      data_read_strobe_n <= 1'b1;
    end
    else
    begin
      address_latch_strobe <= 1'b0;
      muxed_addr_data_lines_oe <= BYTE_ZERO;
      program_read_strobe_n <= 1'b1;
      data_read_strobe_n <= 1'b1;
      if (take && !internal_hit)
      begin
        address_latch_strobe <= 1'b1;
        upper_address_lines <= req_addr[15:8];
        muxed_addr_data_lines_out <= req_addr[7:0];
        muxed_addr_data_lines_oe <= BYTE_ONES;
      end
      else if (state_reg == ST_FLOAT || (state_reg == ST_STROBE && cnt_reg != CNT_ONE))
      begin
        program_read_strobe_n <= !is_code_reg;
        data_read_strobe_n <= is_code_reg;
      end
    end
  end

  // ----------------------------------------
  // Answer
  // ----------------------------------------
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      resp_valid <= 1'b0;
      resp_data <= BYTE_ZERO;
      resp_internal <= 1'b0;
    end
    else
    begin
      resp_valid <= 1'b0;
      if (take && internal_hit)
      begin
        resp_valid <= 1'b1;
        resp_data <= rom_data;
        resp_internal <= 1'b1;
      end
      else if (state_reg == ST_STROBE && cnt_reg == CNT_ONE)
      begin
        resp_valid <= 1'b1;
        resp_data <= bus_in_sync;
        resp_internal <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_ale_with_addr: assert property (address_latch_strobe |-> muxed_addr_data_lines_oe == BYTE_ONES)
    else $error("latch strobe without driven low address");
  a_ale_one_cycle: assert property (address_latch_strobe |=> !address_latch_strobe)
    else $error("latch strobe longer than one cycle");
  a_release_before_strobe: assert property (address_latch_strobe |=> muxed_addr_data_lines_oe == BYTE_ZERO
    && program_read_strobe_n && data_read_strobe_n)
    else $error("lines still driven when strobe may start");
  a_no_drive_in_read: assert property ((!program_read_strobe_n || !data_read_strobe_n)
    |-> muxed_addr_data_lines_oe == BYTE_ZERO)
    else $error("lines driven during read strobe");
  a_strobes_exclusive: assert property (!(!program_read_strobe_n && !data_read_strobe_n))
    else $error("both read strobes low");
  a_code_strobe: assert property ((take && !internal_hit && req_is_code) |-> ##3 !program_read_strobe_n)
    else $error("program strobe missing for external fetch");
  a_data_strobe: assert property ((take && !req_is_code) |-> ##3 !data_read_strobe_n)
    else $error("data strobe missing for data read");
  a_upper_addr: assert property ((take && !internal_hit) |=> upper_address_lines == $past(req_addr[15:8]))
    else $error("upper address wrong");
  a_strap_external: assert property ((take && req_is_code && !strap_reg) |=> address_latch_strobe)
    else $error("fetch not external with strap low");
  a_strap_held: assert property ($stable(strap_reg))
    else $error("strap changed outside reset");
  a_ext_answer: assert property ((take && !internal_hit) |-> ##7 resp_valid && !resp_internal)
    else $error("external answer not on time");
endmodule

/* File: core/ext_bus_pkg.sv */
package ext_bus_pkg;
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned MEM_ACCESS_NS = 150;
  localparam int unsigned MEM_ACCESS_CYCLES = (MEM_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned SYNC_STAGES = 2;
  localparam int unsigned STROBE_CYCLES = MEM_ACCESS_CYCLES + SYNC_STAGES;
  localparam int unsigned CNT_W = 4;
  localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
  localparam logic [CNT_W-1:0] CNT_ONE = 4'h1;
  localparam logic [15:0] ROM_LIMIT_DEFAULT = 16'h2000;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [7:0] BYTE_ONES = 8'hff;
  localparam logic [7:0] UPPER_RESET = 8'hff;
  localparam logic [9:0] SYNC_PASS_IN_RESET = 10'h100;

  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_ADDR = 2'h1,
    ST_FLOAT = 2'h3,
    ST_STROBE = 2'h2
  } bus_state_type;
endpackage

/* File: core/pin_sync_if.sv */
`timescale 1ns/1ns
interface pin_sync_if;
  logic [9:0] raw;
  logic [9:0] synced;
  modport owner (output raw, input synced);
  modport stage (input raw, output synced);
endinterface

/* File: core/pin_sync.sv */
`timescale 1ns/1ns
module pin_sync
  import ext_bus_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  pin_sync_if.stage sig
);
  logic [9:0] first_reg;
  logic [9:0] second_reg;

  // Two flops; the first is read by the second only.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      // The strap bit keeps moving through reset so that it can be captured there.
      first_reg <= sig.raw & SYNC_PASS_IN_RESET;
      second_reg <= first_reg & SYNC_PASS_IN_RESET;
    end
    else
    begin
      first_reg <= sig.raw;
      second_reg <= first_reg;
    end
  end

  assign sig.synced = second_reg;
endmodule

/* File: sim/ext_mem_model.sv */
`timescale 1ns/1ns
// --------------------------------------------------------------
// Off-chip memory with its low address latch.
// --------------------------------------------------------------
module ext_mem_model
(
  input wire logic clk,
  input wire logic ale,
  input wire logic [7:0] upper,
  input wire logic [7:0] pins,
  input wire logic prog_n,
  input wire logic data_n,
  output logic [7:0] lvl
);
  logic [7:0] lo_reg;
  logic [7:0] idle_reg = 8'h5a;
  always_ff @(posedge clk)
  begin
    if (ale)
    begin
      lo_reg <= pins;
    end
    idle_reg <= ~idle_reg;
  end
  // Released lines show a pattern that changes every cycle.
  assign lvl = (!prog_n || !data_n) ? (lo_reg ^ upper ^ (!prog_n ? 8'h3c : 8'hc3)) : idle_reg;
endmodule

/* File: sim/usb_ctrl_external_bus_port_tb_top.sv */
`timescale 1ns/1ns
module usb_ctrl_external_bus_port_tb_top;
  import ext_bus_pkg::*;
  logic clk, rst_n, req_valid, req_is_code, code_source_select, host_interrupt_input;
  logic [15:0] req_addr, rom_addr, a;
  logic [7:0] rom_data, resp_data, upper, pins, out, oe, lvl;
  logic req_ready, resp_valid, resp_internal, ale, prog_n, data_n, modem_host_interrupt, code_source_latched, c;
  logic [31:0] seed = 32'd67165;
  int error_cnt = 0;
  int checks_done = 0;
  // --------------------------------------------------------------
  // Design, memory model and pin resolution.
  // --------------------------------------------------------------
  ext_bus_port #(.ROM_LIMIT(16'h2000)) uut (.clk(clk), .rst_n(rst_n), .req_valid(req_valid), .req_ready(req_ready),
    .req_addr(req_addr), .req_is_code(req_is_code), .resp_valid(resp_valid), .resp_data(resp_data),
    .resp_internal(resp_internal), .rom_addr(rom_addr), .rom_data(rom_data), .address_latch_strobe(ale),
    .upper_address_lines(upper), .muxed_addr_data_lines_in(pins), .muxed_addr_data_lines_out(out),
    .muxed_addr_data_lines_oe(oe), .program_read_strobe_n(prog_n), .data_read_strobe_n(data_n),
    .code_source_select(code_source_select), .host_interrupt_input(host_interrupt_input),
    .modem_host_interrupt(modem_host_interrupt), .code_source_latched(code_source_latched));
  ext_mem_model mem (.clk(clk), .ale(ale), .upper(upper), .pins(pins), .prog_n(prog_n), .data_n(data_n), .lvl(lvl));
  assign pins = (oe & out) | (~oe & lvl);
  assign rom_data = rom_fn(rom_addr);
  // --------------------------------------------------------------
  // Helpers.
  // --------------------------------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    v ^= v << 5;
    return v;
  endfunction
  function automatic logic [7:0] rom_fn(input logic [15:0] x);
    return x[7:0] + x[15:8] + 8'h11;
  endfunction
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    checks_done++;
    if (g !== e)
    begin
      $display("unexpected %s expected %h seen %h", nm, e, g);
      error_cnt++;
    end
  endtask
  task automatic do_reset(input logic strap);
    @(negedge clk);
    rst_n = 0;
    code_source_select = strap;
    repeat (12) @(negedge clk);
    rst_n = 1;
    chk("strap", {15'h0, strap}, {15'h0, code_source_latched});
  endtask
  task automatic req(input logic [15:0] x, input logic k, input logic in_rom);
    logic seen;
    int n;
    seen = 0;
    n = 0;
    @(negedge clk);
    req_valid = 1;
    req_addr = x;
    req_is_code = k;
    @(negedge clk);
    req_valid = 0;
    if (in_rom)
    begin
      chk("rom valid", 16'h1, {15'h0, resp_valid});
      chk("rom data", {8'h1, rom_fn(x)}, {7'h0, resp_internal, resp_data});
    end
    else
    begin
      chk("address phase", {8'h1, x[15:8]}, {7'h0, ale, upper});
      chk("low address", {x[7:0], 8'hff}, {out, oe});
      chk("ready busy", 16'h0, {15'h0, req_ready});
      while (resp_valid !== 1'b1 && n < 12)
      begin
        if (!prog_n || !data_n)
        begin
          seen = 1;
          chk("float", 16'h0, {8'h0, oe});
          chk("strobe kind", k ? 16'h1 : 16'h2, {14'h0, prog_n, data_n});
        end
        @(negedge clk);
        n++;
      end
      chk("strobe seen", 16'h1, {15'h0, seen});
      chk("ready idle", 16'h1, {15'h0, req_ready});
      chk("answer", {8'h0, x[7:0] ^ x[15:8] ^ (k ? 8'h3c : 8'hc3)}, {7'h0, resp_internal, resp_data});
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // --------------------------------------------------------------
  // Clock, watchdog and tests.
  // --------------------------------------------------------------
  initial
  begin
    clk = 0;
    forever #50 clk = ~clk;
  end
  initial
  begin
    #(5000 * 100);
    error_cnt++;
    report_and_stop();
  end
  initial
  begin
    {rst_n, req_valid, req_is_code, code_source_select, host_interrupt_input} = 5'h0;
    req_addr = 16'h0;
    do_reset(0);
    for (int i = 0; i < 20; i++)
    begin
      seed = xs(seed);
      req(seed[15:0], seed[16], 0);
    end
    code_source_select = 1;
    req(16'h0010, 1, 0);
    $display("external fetch test done");
    do_reset(1);
    for (int i = 0; i < 24; i++)
    begin
      seed = xs(seed);
      a = (i == 0) ? 16'h1fff : (i == 1) ? 16'h2000 : {seed[15] & seed[14], seed[14:0]};
      c = seed[16] | (i < 2);
      req(a, c, c && a < 16'h2000);
    end
    $display("on-chip fetch test done");
    for (int i = 0; i < 12; i++)
    begin
      seed = xs(seed);
      host_interrupt_input = seed[3];
      repeat (2) @(negedge clk);
      chk("interrupt", {15'h0, host_interrupt_input}, {15'h0, modem_host_interrupt});
    end
    $display("interrupt test done");
    report_and_stop();
  end
endmodule
